// >>> logic/dcrt_pkg.sv
// Constants, types and helpers of the debug core register transfer block.
// Assumes one clock and an AXI4-Lite master with 32-bit data.
//
// Notes on behaviour
// - Selector write while halted drops ready flag
// - Ready returns to one once word moved
// - Status word written in full, unmasked
// - Conditional block bits writable, debugger keeps consistent
// - Exit hands continuation state to multiple transfer
// - Zero continuation restarts multiple transfer
// - Resume address writable, exit uses latest
// - Debugger transfer can set fault mask at any priority
// - Move instruction blocked at priority minus one
// - Monitor controls sit in bits 23 to 16
// - Halting controls sit in bits 15 to 0
// - Selector bit 16 picks read or write
// - Data word unknown at reset and mid-transfer
// - Data word alone is a plain message word
package dcrt_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0]  OFF_HCS        = 8'h00;
    localparam logic [7:0]  OFF_SEL        = 8'h04;
    localparam logic [7:0]  OFF_DATA       = 8'h08;
    localparam logic [7:0]  OFF_EMC        = 8'h0c;
    localparam int          HCS_HALT_BIT   = 0;
    localparam int          HCS_READY_BIT  = 16;
    localparam int          HCS_HALTED_BIT = 17;
    localparam int          SEL_DIR_BIT    = 16;
    localparam logic [31:0] EMC_MASK       = 32'h00ff_ffff;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ==========================================================
    // Target codes and fields
    localparam logic [6:0]  CODE_LAST_CORE = 7'h12;
    localparam logic [6:0]  CODE_PC        = 7'h0f;
    localparam logic [6:0]  CODE_PSW       = 7'h10;
    localparam logic [6:0]  CODE_MASKS     = 7'h14;
    localparam logic [6:0]  CODE_FPSCR     = 7'h21;
    localparam logic [5:0]  IDX_FPSCR      = 6'h15;
    localparam logic [5:0]  IDX_PC         = 6'h0f;
    localparam logic [5:0]  IDX_PSW        = 6'h10;
    localparam logic [5:0]  IDX_MASKS      = 6'h14;
    localparam int          FAULT_MASK_BIT = 16;
    localparam int          BANK_DEPTH     = 64;
    localparam logic [3:0]  XFER_CYCLES    = 4'h2;

    typedef enum logic {XF_IDLE, XF_BUSY} dcrt_xfer_t;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] dcrt_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : dcrt_merge

    function automatic logic dcrt_code_ok(input logic [6:0] c);
        return (c <= CODE_LAST_CORE) || (c == CODE_MASKS) ||
               (c == CODE_FPSCR) || (c[6:5] == 2'h2);
    endfunction : dcrt_code_ok

    function automatic logic [5:0] dcrt_code_idx(input logic [6:0] c);
        if (c[6]) return {1'b1, c[4:0]};
        if (c == CODE_FPSCR) return IDX_FPSCR;
        return c[5:0];
    endfunction : dcrt_code_idx

    // Conditional block and continuation share these status bits
    function automatic logic [7:0] dcrt_cond(input logic [31:0] psw);
        return {psw[15:10], psw[26:25]};
    endfunction : dcrt_cond
endpackage : dcrt_pkg

// >>> logic/dcrt_target_bank.sv
// Flip-flop bank holding the processor's transferable registers.
// Assumes one write per cycle; read data appears one cycle after index.
`timescale 1ns/1ps
module dcrt_target_bank (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        we,
    input  wire logic [5:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    input  wire logic [5:0]  rd_idx,
    output logic      [31:0] rd_data,
    output logic      [31:0] pc_word,
    output logic      [31:0] psw_word,
    output logic      [31:0] mask_word
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [dcrt_pkg::BANK_DEPTH-1:0][31:0] w;
        logic [31:0]                           rd;
    } dcrt_bank_t;

    dcrt_bank_t s;
    dcrt_bank_t next_s;

    always_comb begin
        next_s = s;
        next_s.rd = s.w[rd_idx];
        if (we) next_s.w[wr_idx] = wr_data;
    end

    // Cleared for determinism; software must not rely on it
    always_ff @(posedge aclk) begin
        if (!aresetn) s <= '0;
        else s <= next_s;
    end

    assign rd_data   = s.rd;
    assign pc_word   = s.w[dcrt_pkg::IDX_PC];
    assign psw_word  = s.w[dcrt_pkg::IDX_PSW];
    assign mask_word = s.w[dcrt_pkg::IDX_MASKS];
endmodule : dcrt_target_bank

// >>> logic/dcrt_top.sv
// Debug register transfer engine with AXI4-Lite register slave.
// Assumes the core samples exit outputs on exit_valid and gives one
// special-register move per cycle on the core_move port.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dcrt_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        core_move_valid,
    input  wire logic        core_move_mask,
    input  wire logic [9:0]  core_exec_pri,
    input  wire logic        core_msg_valid,
    input  wire logic [31:0] core_msg_data,
    output logic             halted,
    output logic             exit_valid,
    output logic      [31:0] exit_pc,
    output logic      [7:0]  exit_cond,
    output logic             exit_restart,
    output logic             fault_mask,
    output logic      [7:0]  mon_ctl,
    output logic      [15:0] halt_ctl,
    output logic      [31:0] msg_data
);
    // ==========================================================
    // State
    typedef struct packed {
        logic                aw_got;
        logic                w_got;
        logic [7:0]          awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic                halt_req;
        logic                halted;
        logic                ready;
        logic [6:0]          sel_code;
        logic                sel_dir;
        dcrt_pkg::dcrt_xfer_t xstate;
        logic [3:0]          cnt;
        logic [31:0]         data;
        logic [31:0]         emc;
        logic                exit_valid;
        logic [31:0]         exit_pc;
        logic [7:0]          exit_cond;
        logic                exit_restart;
    } dcrt_state_t;

    dcrt_state_t s;
    dcrt_state_t next_s;

    logic        do_wr;
    logic        hit_hcs;
    logic        hit_sel;
    logic        hit_data;
    logic        hit_emc;
    logic        move_now;
    logic        code_ok;
    logic        dbg_we;
    logic        move_we;
    logic        bk_we;
    logic [5:0]  bk_idx;
    logic [31:0] bk_wdata;
    logic [31:0] bk_rdata;
    logic [31:0] pc_word;
    logic [31:0] psw_word;
    logic [31:0] mask_word;
    logic        pri_high;

    // ==========================================================
    // Decode
    assign do_wr    = s.aw_got && s.w_got && !s.bvalid;
    assign hit_hcs  = s.awaddr == dcrt_pkg::OFF_HCS;
    assign hit_sel  = s.awaddr == dcrt_pkg::OFF_SEL;
    assign hit_data = s.awaddr == dcrt_pkg::OFF_DATA;
    assign hit_emc  = s.awaddr == dcrt_pkg::OFF_EMC;
    assign move_now = (s.xstate == dcrt_pkg::XF_BUSY) && (s.cnt == 4'h0);
    assign code_ok  = dcrt_pkg::dcrt_code_ok(s.sel_code);
    assign pri_high = $signed(core_exec_pri) >= -10'sd1;

    // Debugger path writes unmasked, move instruction is gated
    assign dbg_we   = move_now && s.sel_dir && code_ok;
    assign move_we  = core_move_valid &&
                      !(core_move_mask && pri_high);
    assign bk_we    = dbg_we || move_we;
    assign bk_idx   = dbg_we ? dcrt_pkg::dcrt_code_idx(s.sel_code)
                             : dcrt_pkg::IDX_MASKS;

    always_comb begin
        bk_wdata = mask_word;
        bk_wdata[dcrt_pkg::FAULT_MASK_BIT] = core_move_mask;
        if (dbg_we) begin
            bk_wdata = s.data;
            if (s.sel_code == dcrt_pkg::CODE_PC) begin
                bk_wdata = {s.data[31:1], 1'b0};
            end
        end
    end

    dcrt_target_bank u_bank (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .we        (bk_we),
        .wr_idx    (bk_idx),
        .wr_data   (bk_wdata),
        .rd_idx    (dcrt_pkg::dcrt_code_idx(s.sel_code)),
        .rd_data   (bk_rdata),
        .pc_word   (pc_word),
        .psw_word  (psw_word),
        .mask_word (mask_word)
    );

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.exit_valid = 1'b0;
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (bready && s.bvalid) next_s.bvalid = 1'b0;

        // Transfer engine; the data word is undefined until ready
        if (s.xstate == dcrt_pkg::XF_BUSY) begin
            if (move_now) begin
                if (!s.sel_dir) begin
                    next_s.data = code_ok ? bk_rdata
                                          : dcrt_pkg::RST_WORD;
                end
                next_s.ready = 1'b1;
                next_s.xstate = dcrt_pkg::XF_IDLE;
            end else begin
                next_s.cnt = s.cnt - 4'h1;
            end
        end

        // Message word written by monitor software on the core
        if (core_msg_valid) next_s.data = core_msg_data;

        if (do_wr) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = dcrt_pkg::RESP_OKAY;
            if (hit_hcs) begin
                next_s.halt_req = s.wdata[dcrt_pkg::HCS_HALT_BIT] &&
                                  s.wstrb[0];
            end else if (hit_sel) begin
                // Ignored while running: nothing to transfer
                if (s.halted) begin
                    next_s.sel_code = s.wdata[6:0];
                    next_s.sel_dir = s.wdata[dcrt_pkg::SEL_DIR_BIT];
                    next_s.ready = 1'b0;
                    next_s.xstate = dcrt_pkg::XF_BUSY;
                    next_s.cnt = dcrt_pkg::XFER_CYCLES;
                end
            end else if (hit_data) begin
                next_s.data = dcrt_pkg::dcrt_merge(s.data, s.wdata,
                                                   s.wstrb);
            end else if (hit_emc) begin
                next_s.emc = dcrt_pkg::dcrt_merge(s.emc, s.wdata,
                                 s.wstrb) & dcrt_pkg::EMC_MASK;
            end else begin
                next_s.bresp = dcrt_pkg::RESP_SLVERR;
            end
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        // Read channel; reads have no side effects
        if (rready && s.rvalid) next_s.rvalid = 1'b0;
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = dcrt_pkg::RESP_OKAY;
            next_s.rdata = dcrt_pkg::RST_WORD;
            case (araddr)
                dcrt_pkg::OFF_HCS: begin
                    next_s.rdata[dcrt_pkg::HCS_HALT_BIT] = s.halt_req;
                    next_s.rdata[dcrt_pkg::HCS_READY_BIT] = s.ready;
                    next_s.rdata[dcrt_pkg::HCS_HALTED_BIT] = s.halted;
                end
                dcrt_pkg::OFF_SEL: next_s.rdata = dcrt_pkg::RST_WORD;
                dcrt_pkg::OFF_DATA: next_s.rdata = s.data;
                dcrt_pkg::OFF_EMC: next_s.rdata = s.emc;
                default: next_s.rresp = dcrt_pkg::RESP_SLVERR;
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // Halt follows the request a cycle later; exit hands over state
        next_s.halted = s.halt_req;
        if (s.halted && !s.halt_req) begin
            next_s.exit_valid = 1'b1;
            next_s.exit_pc = pc_word;
            next_s.exit_cond = dcrt_pkg::dcrt_cond(psw_word);
            next_s.exit_restart =
                dcrt_pkg::dcrt_cond(psw_word) == 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.ready <= 1'b1;
            s.xstate <= dcrt_pkg::XF_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign awready      = s.awready;
    assign wready       = s.wready;
    assign bvalid       = s.bvalid;
    assign bresp        = s.bresp;
    assign arready      = s.arready;
    assign rvalid       = s.rvalid;
    assign rdata        = s.rdata;
    assign rresp        = s.rresp;
    assign halted       = s.halted;
    assign exit_valid   = s.exit_valid;
    assign exit_pc      = s.exit_pc;
    assign exit_cond    = s.exit_cond;
    assign exit_restart = s.exit_restart;
    assign fault_mask   = mask_word[dcrt_pkg::FAULT_MASK_BIT];
    assign mon_ctl      = s.emc[23:16];
    assign halt_ctl     = s.emc[15:0];
    assign msg_data     = s.data;

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence sel_taken;
        do_wr && hit_sel && s.halted;
    endsequence
    sequence quiet3;
        (!do_wr) [*3];
    endsequence
    sequence exit_now;
        s.halted && !s.halt_req;
    endsequence

    a_sel_ready_low: assert property (sel_taken |=> !s.ready)
        else $error("ready flag not cleared by selector write");
    a_ready_rise_cause: assert property ($rose(s.ready) |-> $past(move_now))
        else $error("ready flag rose without a completed move");
    a_ready_latency: assert property (sel_taken ##1 quiet3 |=> s.ready)
        else $error("transfer did not complete in three cycles");
    a_ready_hold: assert property (!(do_wr && hit_sel && s.halted) &&
                                   !move_now |=> $stable(s.ready))
        else $error("ready flag changed without cause");
    a_psw_full: assert property (dbg_we && s.sel_code == dcrt_pkg::CODE_PSW
                                 |=> psw_word == $past(s.data))
        else $error("status word not written in full");
    a_pc_written: assert property (dbg_we && s.sel_code == dcrt_pkg::CODE_PC
                                   |=> pc_word == {$past(s.data[31:1]), 1'b0})
        else $error("resume address not written");
    a_exit_resume: assert property (exit_now
                                    |=> exit_valid && exit_pc == $past(pc_word))
        else $error("exit did not use latest resume address");
    a_exit_cont: assert property (exit_now |=> exit_cond ==
                                  {$past(psw_word[15:10]),
                                   $past(psw_word[26:25])} &&
                                  exit_restart == (exit_cond == 8'h00))
        else $error("continuation state not handed over on exit");
    a_mask_debug: assert property (dbg_we &&
                                   s.sel_code == dcrt_pkg::CODE_MASKS &&
                                   s.data[dcrt_pkg::FAULT_MASK_BIT]
                                   |=> fault_mask)
        else $error("debugger could not set fault mask");
    a_move_blocked: assert property (core_move_valid && core_move_mask &&
                                     pri_high && !dbg_we && !fault_mask
                                     |=> !fault_mask)
        else $error("move instruction set fault mask at high priority");
    a_emc_split: assert property (do_wr && hit_emc && s.wstrb == 4'hf
                                  |=> mon_ctl == $past(s.wdata[23:16]) &&
                                  halt_ctl == $past(s.wdata[15:0]))
        else $error("control register halves misplaced");
    a_read_fetch: assert property (move_now && !s.sel_dir && code_ok &&
                                   !core_msg_valid && !do_wr
                                   |=> s.data == $past(bk_rdata))
        else $error("fetched word not placed in data register");
    a_msg_word: assert property (do_wr && hit_data && s.wstrb == 4'hf
                                 |=> s.data == $past(s.wdata))
        else $error("message word not stored");
endmodule : dcrt_top

// >>> bench/dcrt_dbg_model.sv
// Debugger model: AXI4-Lite master and register transfer sequences.
// Assumes the slave always answers; the bench watchdog cuts any hang.
`timescale 1ns/1ps
module dcrt_dbg_model (
    input  wire logic        aclk,
    output logic      [7:0]  awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic      [31:0] wdata,
    output logic      [3:0]  wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic      [7:0]  araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // ==========================================================
    // Bus cycles; released address and data lines show the inverse, not a stale value
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
            if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
    // ==========================================================
    // Transfer sequences
    task automatic poll(output logic ok);
        logic [31:0] v;
        logic [1:0]  r;
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            rd(dcrt_pkg::OFF_HCS, v, r);
            ok = v[dcrt_pkg::HCS_READY_BIT];
        end
    endtask : poll
    task automatic put(input logic [6:0] c, input logic [31:0] w,
                       output logic ok);
        logic [1:0] r;
        wr(dcrt_pkg::OFF_DATA, w, 4'hf, r);
        wr(dcrt_pkg::OFF_SEL, {15'h0, 1'b1, 9'h0, c}, 4'hf, r);
        poll(ok);
    endtask : put
    task automatic get(input logic [6:0] c, output logic [31:0] w,
                       output logic ok);
        logic [1:0] r;
        wr(dcrt_pkg::OFF_SEL, {15'h0, 1'b0, 9'h0, c}, 4'hf, r);
        poll(ok);
        rd(dcrt_pkg::OFF_DATA, w, r);
    endtask : get
endmodule : dcrt_dbg_model

// >>> bench/dcrt_tb_top.sv
// Bench top: clock, reset, core stimulus, reference values, checks.
// Assumes the debugger model owns the whole register bus.
`timescale 1ns/1ps
module dcrt_tb_top;
    logic        aclk, aresetn, core_move_valid, core_move_mask, ok;
    logic        core_msg_valid, cap_rst;
    logic [9:0]  core_exec_pri;
    logic [31:0] core_msg_data, v, w, cap_pc;
    logic [7:0]  cap_cond;
    logic [1:0]  r, r2;
    wire  [7:0]  awaddr, araddr, exit_cond, mon_ctl;
    wire  [31:0] wdata, rdata, exit_pc, msg_data;
    wire  [3:0]  wstrb;
    wire  [1:0]  bresp, rresp;
    wire  [15:0] halt_ctl;
    wire         awvalid, awready, wvalid, wready, bvalid, bready;
    wire         arvalid, arready, rvalid, rready, halted, exit_valid;
    wire         exit_restart, fault_mask;
    int          num_errors = 0, comparisons = 0;
    integer      seed = 32'h353a;
    logic [31:0] bank_m [int];
    logic [6:0]  codes [10] = '{7'h00, 7'h0c, 7'h12, 7'h0f, 7'h10,
                                7'h14, 7'h21, 7'h40, 7'h5f, 7'h13};
    dcrt_top dcrt_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .core_move_valid, .core_move_mask, .core_exec_pri, .core_msg_valid,
        .core_msg_data, .halted, .exit_valid, .exit_pc, .exit_cond,
        .exit_restart, .fault_mask, .mon_ctl, .halt_ctl, .msg_data);
    dcrt_dbg_model dcrt_dbg_model_inst (.aclk, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    // ==========================================================
    // Checking and closing
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(string n, logic [7:0] a, logic [31:0] e,
                        logic [1:0] er);
        dcrt_dbg_model_inst.rd(a, v, r);
        chk(n, e, v);
        chk({n, " resp"}, {30'h0, er}, {30'h0, r});
    endtask : rchk
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    // Core special-register move; lower priority only may set the mask
    task automatic mv(logic m, logic [9:0] p, logic e);
        {core_move_mask, core_exec_pri, core_move_valid} <= {m, p, 1'b1};
        @(posedge aclk);
        core_move_valid <= 1'b0;
        @(posedge aclk);
        chk("fault_mask", {31'h0, e}, {31'h0, fault_mask});
    endtask : mv
    always @(posedge aclk) if (exit_valid === 1'b1) begin
        {cap_pc, cap_cond, cap_rst} <= {exit_pc, exit_cond, exit_restart};
    end
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        conclude();
    end
    // ==========================================================
    // Tests
    initial begin
        {aresetn, core_move_valid, core_move_mask, core_msg_valid} = '0;
        {core_exec_pri, core_msg_data} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("status", dcrt_pkg::OFF_HCS, 32'h0001_0000, 2'h0);
        rchk("unmapped", 8'h10, 32'h0, dcrt_pkg::RESP_SLVERR);
        $display("test reset done");
        w = $random(seed);
        dcrt_dbg_model_inst.wr(dcrt_pkg::OFF_DATA, w, 4'hf, r);
        dcrt_dbg_model_inst.wr(dcrt_pkg::OFF_DATA, 32'h0, 4'h2, r);
        rchk("msg", dcrt_pkg::OFF_DATA, w & 32'hffff_00ff, 2'h0);
        {core_msg_data, core_msg_valid} <= {~w, 1'b1};
        @(posedge aclk);
        core_msg_valid <= 1'b0;
        @(posedge aclk);
        chk("msg_data", ~w, msg_data);
        $display("test message done");
        w = $random(seed);
        dcrt_dbg_model_inst.wr(dcrt_pkg::OFF_EMC, w, 4'hf, r);
        chk("mon_ctl", {24'h0, w[23:16]}, {24'h0, mon_ctl});
        chk("halt_ctl", {16'h0, w[15:0]}, {16'h0, halt_ctl});
        rchk("control", dcrt_pkg::OFF_EMC, w & dcrt_pkg::EMC_MASK, 2'h0);
        dcrt_dbg_model_inst.wr(dcrt_pkg::OFF_HCS, 32'h1, 4'h1, r);
        rchk("halted", dcrt_pkg::OFF_HCS, 32'h0003_0001, 2'h0);
        chk("halted pin", 32'h1, {31'h0, halted});
        fork
            dcrt_dbg_model_inst.wr(dcrt_pkg::OFF_SEL, 32'h0, 4'hf, r);
            begin
                repeat (3) @(posedge aclk);
                dcrt_dbg_model_inst.rd(dcrt_pkg::OFF_HCS, w, r2);
            end
        join
        chk("ready low", 32'h0002_0001, w);
        dcrt_dbg_model_inst.poll(ok);
        chk("ready", 32'h1, {31'h0, ok});
        rchk("ready held", dcrt_pkg::OFF_HCS, 32'h0003_0001, 2'h0);
        $display("test handshake done");
        foreach (codes[i]) begin
            w = $random(seed);
            w[0] = (codes[i] == dcrt_pkg::CODE_PC) ? 1'b0 : w[0];
            dcrt_dbg_model_inst.put(codes[i], w, ok);
            chk("put ready", 32'h1, {31'h0, ok});
            bank_m[codes[i]] = (codes[i] == 7'h13) ? 32'h0 : w;
        end
        foreach (codes[i]) begin
            dcrt_dbg_model_inst.get(codes[i], w, ok);
            chk("get", bank_m[codes[i]], w);
        end
        $display("test targets done");
        dcrt_dbg_model_inst.put(dcrt_pkg::CODE_MASKS, 32'h0001_0000, ok);
        chk("fault_mask", 32'h1, {31'h0, fault_mask});
        mv(1'b0, 10'h3ff, 1'b0);
        mv(1'b1, 10'h3ff, 1'b0);
        mv(1'b1, 10'h3fe, 1'b1);
        $display("test fault mask done");
        for (int k = 0; k < 2; k++) begin
            w = $random(seed) & 32'hffff_fffe;
            v = $random(seed) | 32'h0000_0400;
            if (k == 1) v = v & 32'hf9ff_03ff;
            dcrt_dbg_model_inst.put(dcrt_pkg::CODE_PC, w, ok);
            dcrt_dbg_model_inst.put(dcrt_pkg::CODE_PSW, v, ok);
            dcrt_dbg_model_inst.wr(dcrt_pkg::OFF_HCS, 32'h0, 4'h1, r);
            repeat (3) @(posedge aclk);
            chk("halted pin", 32'h0, {31'h0, halted});
            chk("exit_pc", w, cap_pc);
            chk("exit_cond", {24'h0, v[15:10], v[26:25]}, {24'h0, cap_cond});
            chk("exit_restart", k, {31'h0, cap_rst});
            dcrt_dbg_model_inst.wr(dcrt_pkg::OFF_HCS, 32'h1, 4'h1, r);
        end
        $display("test exit done");
        conclude();
    end
endmodule : dcrt_tb_top
